// file: src/jcrc_ctrl.sv
// Boundary scan configuration loader with readback control.
// Assumes the scan, clear and readback pins are asynchronous to ref_clk and sampled twice.
`timescale 1ns/10ps
`default_nettype none
module jcrc_ctrl #(
    parameter int FRAME_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tck,
    input wire logic tdi,
    input wire logic shift_dr,
    input wire logic init_n_in,
    output logic init_n_out,
    output logic init_n_oe,
    input wire logic readback_trigger,
    input wire logic readback_user_clock,
    output logic readback_in_progress,
    output logic readback_data,
    output logic cfg_shift_clock,
    output logic cfg_done,
    output logic irq
);
    typedef enum logic [1:0] {CF_IDLE, CF_LOAD, CF_DONE, CF_WAIT} jcrc_cfg_t;

    jcrc_pkg::jcrc_pins_t raw_ff, pin_ff, prev_ff;
    jcrc_cfg_t cfg_state_ff;
    logic [5:0] ctrl_ff;
    logic [3:0] irq_stat_ff, irq_mask_ff;
    logic [jcrc_pkg::LEN_W-1:0] len_ff, cnt_ff;
    logic [31:0] frame_len_ff;
    logic [31:0] bit_pos_ff;
    logic [FRAME_W-1:0] rb_shift_ff, frame_src_ff;
    logic [9:0] div_ff;
    logic rb_active_ff, wait_ff;
    logic [3:0] ev;

    function automatic logic rose(input logic now, input logic was);
        return now & ~was;
    endfunction

    // Two-flop synchronisers plus an edge-detect stage; logic reads the second and third stages
    always_ff @(posedge ref_clk) begin
        raw_ff <= {tck, tdi, shift_dr, init_n_in, readback_trigger,
                   readback_user_clock};
        pin_ff <= raw_ff;
        prev_ff <= pin_ff;
    end

    wire tck_rise = rose(pin_ff.tck, prev_ff.tck);
    wire clr_rise = rose(pin_ff.init_n, prev_ff.init_n);
    wire trig_rise = rose(pin_ff.trig, prev_ff.trig);
    wire trig_fall = rose(prev_ff.trig, pin_ff.trig);
    // Readback clock source: own config clock or the user pin
    wire rb_edge = ctrl_ff[jcrc_pkg::CTRL_USER_CLK] ?
        rose(pin_ff.ucl, prev_ff.ucl) :
        (div_ff == 10'h000 && !cfg_shift_clock);
    wire in_load = bit_pos_ff >= frame_len_ff -
        32'(jcrc_pkg::LOAD_CYCLES);
    wire frame_err = ctrl_ff[jcrc_pkg::CTRL_FRAME_ERR];
    wire bus_go = (avs_read | avs_write) & avs_waitrequest;

    // Configuration clock divider, half period per selected speed
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_ff <= 10'h000;
            cfg_shift_clock <= 1'b0;
        end else if (!ctrl_ff[jcrc_pkg::CTRL_MASTER]) begin
            div_ff <= 10'h000;
            cfg_shift_clock <= 1'b0;
        end else if (div_ff == 10'h000) begin
            div_ff <= ctrl_ff[jcrc_pkg::CTRL_FAST] ?
                10'(jcrc_pkg::FAST_HALF - 1) :
                10'(jcrc_pkg::SLOW_HALF - 1);
            cfg_shift_clock <= ~cfg_shift_clock;
        end else begin
            div_ff <= div_ff - 10'h001;
        end
    end

    // Configuration load: length count, TCK counting, error wait
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_state_ff <= CF_IDLE;
            len_ff <= '0;
            cnt_ff <= '0;
        end else begin
            unique case (cfg_state_ff)
                CF_IDLE: if (clr_rise) begin
                    cfg_state_ff <= CF_LOAD;
                    cnt_ff <= '0;
                end
                CF_LOAD: begin
                    if (frame_err) begin
                        cfg_state_ff <= CF_WAIT;
                    end else if (tck_rise) begin
                        cnt_ff <= cnt_ff + 1'b1;
                        if (pin_ff.shift_dr && cnt_ff < 24'(jcrc_pkg::LEN_W)) begin
                            len_ff <= {len_ff[22:0], pin_ff.tdi};
                        end
                        if (cnt_ff >= 24'(jcrc_pkg::LEN_W) &&
                            cnt_ff + 1'b1 == len_ff) begin
                            cfg_state_ff <= CF_DONE;
                        end
                    end
                end
                CF_DONE: ;
                CF_WAIT: ;
            endcase
        end
    end

    // Memory-clear pin is driven low only while waiting after an error
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            init_n_out <= 1'b0;
            init_n_oe <= 1'b0;
            cfg_done <= 1'b0;
            wait_ff <= 1'b0;
        end else begin
            init_n_out <= 1'b0;
            init_n_oe <= cfg_state_ff == CF_WAIT;
            cfg_done <= cfg_state_ff == CF_DONE;
            wait_ff <= cfg_state_ff == CF_WAIT;
        end
    end

    // Readback: trigger start, abort, frame position and load window
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rb_active_ff <= 1'b0;
            bit_pos_ff <= '0;
            rb_shift_ff <= '0;
            frame_src_ff <= '0;
            readback_data <= 1'b0;
        end else if (!ctrl_ff[jcrc_pkg::CTRL_RB_EN]) begin
            rb_active_ff <= 1'b0;
            bit_pos_ff <= '0;
        end else if (rb_active_ff && trig_fall &&
                     ctrl_ff[jcrc_pkg::CTRL_ABORT_EN]) begin
            rb_active_ff <= 1'b0;
            bit_pos_ff <= '0;
        end else if (!rb_active_ff) begin
            if (trig_rise && cfg_state_ff == CF_DONE) begin
                rb_active_ff <= 1'b1;
                bit_pos_ff <= frame_len_ff - 32'(jcrc_pkg::LOAD_CYCLES);
            end
        end else if (rb_edge) begin
            if (in_load) begin
                // Dynamic transfer of the next frame image
                rb_shift_ff <= frame_src_ff;
                frame_src_ff <= frame_src_ff + 1'b1;
            end else begin
                rb_shift_ff <= {rb_shift_ff[FRAME_W-2:0], 1'b0};
            end
            readback_data <= rb_shift_ff[FRAME_W-1];
            if (bit_pos_ff == frame_len_ff - 32'h1) begin
                bit_pos_ff <= '0;
                if (frame_src_ff == '1) rb_active_ff <= 1'b0;
            end else begin
                bit_pos_ff <= bit_pos_ff + 32'h1;
            end
        end
    end

    // Status output follows the active flag
    always_ff @(posedge ref_clk) begin
        if (rst) readback_in_progress <= 1'b0;
        else readback_in_progress <= rb_active_ff;
    end

    // Events feeding sticky status
    assign ev = {rb_active_ff && trig_fall &&
                 ctrl_ff[jcrc_pkg::CTRL_ABORT_EN],
                 readback_in_progress && !rb_active_ff,
                 cfg_state_ff == CF_WAIT && !wait_ff,
                 cfg_state_ff == CF_DONE && !cfg_done};

    // Sticky interrupt status; a read clears but a new event wins
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_stat_ff <= '0;
        end else if (bus_go && avs_read &&
                     avs_address == jcrc_pkg::OFF_IRQ_STAT) begin
            irq_stat_ff <= ev;
        end else begin
            irq_stat_ff <= irq_stat_ff | ev;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) irq <= 1'b0;
        else irq <= |(irq_stat_ff & irq_mask_ff);
    end

    // Avalon slave: one wait cycle, then answer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= '0;
            ctrl_ff <= jcrc_pkg::CTRL_RESET;
            irq_mask_ff <= '0;
            frame_len_ff <= jcrc_pkg::FRAME_LEN_RESET;
        end else begin
            avs_waitrequest <= !bus_go;
            if (bus_go && avs_write) begin
                unique case (avs_address)
                    jcrc_pkg::OFF_CTRL: ctrl_ff <= avs_writedata[5:0];
                    jcrc_pkg::OFF_IRQ_MASK: irq_mask_ff <= avs_writedata[3:0];
                    jcrc_pkg::OFF_STATUS: frame_len_ff <= avs_writedata;
                    default: ;
                endcase
            end
            if (bus_go && avs_read) begin
                unique case (avs_address)
                    jcrc_pkg::OFF_CTRL: avs_readdata <= {26'h0, ctrl_ff};
                    jcrc_pkg::OFF_STATUS: avs_readdata <= {4'h0, cnt_ff,
                        readback_in_progress, cfg_state_ff, 1'b0};
                    jcrc_pkg::OFF_IRQ_STAT: avs_readdata <= {28'h0, irq_stat_ff};
                    jcrc_pkg::OFF_IRQ_MASK: avs_readdata <= {28'h0, irq_mask_ff};
                    default: avs_readdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Checks
    rip_level_a: assert property (@(posedge ref_clk) disable iff (rst)
        readback_in_progress == $past(rb_active_ff))
        else $error("in-progress output wrong");
    abort_end_a: assert property (@(posedge ref_clk) disable iff (rst)
        rb_active_ff && trig_fall && ctrl_ff[jcrc_pkg::CTRL_ABORT_EN]
        |=> !rb_active_ff ##1 !readback_in_progress)
        else $error("abort did not end readback");
    inhibit_a: assert property (@(posedge ref_clk) disable iff (rst)
        !ctrl_ff[jcrc_pkg::CTRL_RB_EN] |=> !rb_active_ff)
        else $error("readback while inhibited");
    err_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state_ff == CF_LOAD && frame_err |=> cfg_state_ff == CF_WAIT
        ##1 (init_n_oe && !init_n_out))
        else $error("error did not clear pin");
    count_tck_a: assert property (@(posedge ref_clk) disable iff (rst)
        cfg_state_ff == CF_LOAD && !frame_err && tck_rise
        |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("TCK not counted");
    done_len_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(cfg_state_ff == CF_DONE) |-> cnt_ff == len_ff)
        else $error("done before length");
    load_win_a: assert property (@(posedge ref_clk) disable iff (rst)
        rb_active_ff && rb_edge && in_load && ctrl_ff[jcrc_pkg::CTRL_RB_EN]
        && !(trig_fall && ctrl_ff[jcrc_pkg::CTRL_ABORT_EN])
        |=> rb_shift_ff == $past(frame_src_ff))
        else $error("frame not loaded");
    static_a: assert property (@(posedge ref_clk) disable iff (rst)
        !rb_edge |=> $stable(rb_shift_ff))
        else $error("shift moved without clock");
    slow_clk_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(cfg_shift_clock) && !ctrl_ff[jcrc_pkg::CTRL_FAST]
        |=> cfg_shift_clock [*8])
        else $error("slow clock too short");
    fast_clk_a: assert property (@(posedge ref_clk) disable iff (rst)
        $rose(cfg_shift_clock) && ctrl_ff[jcrc_pkg::CTRL_FAST]
        && ctrl_ff[jcrc_pkg::CTRL_MASTER] |-> ##25 !cfg_shift_clock)
        else $error("fast clock half period off");
    user_clk_a: assert property (@(posedge ref_clk) disable iff (rst)
        ctrl_ff[jcrc_pkg::CTRL_USER_CLK] && rb_edge |-> pin_ff.ucl)
        else $error("user clock edge wrong");
    cv_done_c: cover property (@(posedge ref_clk) $rose(cfg_done));
    cv_abort_c: cover property (@(posedge ref_clk) ev[3]);
    cv_rb_c: cover property (@(posedge ref_clk) $fell(readback_in_progress));
endmodule // jcrc_ctrl
`default_nettype wire

// file: src/jcrc_pkg.sv
// Package for the boundary scan configuration loader and readback control.
// Assumes a 250 MHz system clock and Avalon-MM register access.
package jcrc_pkg;
    // Register byte offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h4;
    localparam logic [3:0] OFF_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFF_IRQ_MASK = 4'hc;
    // Control register bit positions
    localparam int CTRL_MASTER = 0;
    localparam int CTRL_FAST = 1;
    localparam int CTRL_ABORT_EN = 2;
    localparam int CTRL_USER_CLK = 3;
    localparam int CTRL_RB_EN = 4;
    localparam int CTRL_FRAME_ERR = 5;
    localparam logic [5:0] CTRL_RESET = 6'h00;
    // Interrupt status bit positions
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR = 1;
    localparam int IRQ_RB_END = 2;
    localparam int IRQ_ABORT = 3;
    // Timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int SLOW_PERIOD_NS = 1000;
    localparam int FAST_PERIOD_NS = 200;
    localparam int SLOW_HALF = SLOW_PERIOD_NS / CLK_PERIOD_NS / 2;
    localparam int FAST_HALF = FAST_PERIOD_NS / CLK_PERIOD_NS / 2;
    localparam int LOAD_CYCLES = 6;
    localparam int LEN_W = 24;
    localparam logic [31:0] FRAME_LEN_RESET = 32'h00000040;
    // Synchronised pins bundle
    typedef struct packed {
        logic tck;
        logic tdi;
        logic shift_dr;
        logic init_n;
        logic trig;
        logic ucl;
    } jcrc_pins_t;
endpackage

// file: test/jcrc_scan_model.sv
// Behavioural scan controller and readback host facing the loader.
// Assumes the bench calls its tasks right after a rising ref_clk edge.
`timescale 1ns/10ps
`default_nettype none
module jcrc_scan_model (
    input wire logic ref_clk,
    output logic tck,
    output logic tdi,
    output logic shift_dr,
    output logic init_drv,
    output logic readback_trigger,
    output logic readback_user_clock
);
    int bit_idx;
    // Clear pin low from power-up; clocks parked until a frame starts
    initial begin
        tck = 1'b0;
        tdi = 1'b0;
        shift_dr = 1'b0;
        init_drv = 1'b0;
        readback_trigger = 1'b0;
        readback_user_clock = 1'b0;
        bit_idx = 0;
    end
    // Pin low long enough for the instruction load, then released.
    // A low phase first makes a fresh rise even after a mid-run reset.
    task release_clear;
        @(posedge ref_clk);
        init_drv <= 1'b0;
        repeat (8) @(posedge ref_clk);
        init_drv <= 1'b1;
        bit_idx = 0;
    endtask
    // Exactly n scan clocks, length word first, MSB first
    task shift_bits(input int n, input logic [23:0] len, input logic [31:0] fill);
        shift_dr <= (n > 0);
        for (int i = 0; i < n; i++) begin
            tdi <= (bit_idx < 24) ? len[23 - bit_idx] : fill[i % 32];
            repeat (6) @(posedge ref_clk);
            tck <= 1'b1;
            repeat (6) @(posedge ref_clk);
            tck <= 1'b0;
            bit_idx++;
        end
        // Released data line must not keep its last value
        tdi <= ~tdi;
        shift_dr <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Steady 48 ns readback clock, never paused mid-burst
    task rb_clocks(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (6) @(posedge ref_clk);
            readback_user_clock <= 1'b1;
            repeat (6) @(posedge ref_clk);
            readback_user_clock <= 1'b0;
        end
    endtask
    task trig(input logic v);
        @(posedge ref_clk);
        readback_trigger <= v;
    endtask
endmodule // jcrc_scan_model
`default_nettype wire

// file: test/jcrc_ctrl_tb.sv
// Self-checking bench for the scan configuration loader.
// Assumes jcrc_pkg and the scan controller model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module jcrc_ctrl_tb;
    logic ref_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic tck, tdi, shift_dr, init_drv, init_n_in, init_n_out, init_n_oe;
    logic readback_trigger, readback_user_clock, readback_in_progress;
    logic readback_data, cfg_shift_clock, cfg_done, irq;
    int miscompares, n_compared, seed, len, k, exp_stat;
    // Pin level: the device pull-down overrides the controller
    assign init_n_in = (init_n_oe === 1'b1) ? 1'b0 : init_drv;
    jcrc_ctrl jcrc_ctrl_i (.ref_clk, .rst, .avs_address, .avs_read,
        .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .tck,
        .tdi, .shift_dr, .init_n_in, .init_n_out, .init_n_oe,
        .readback_trigger, .readback_user_clock, .readback_in_progress,
        .readback_data, .cfg_shift_clock, .cfg_done, .irq);
    jcrc_scan_model jcrc_scan_model_i (.ref_clk, .tck, .tdi, .shift_dr,
        .init_drv, .readback_trigger, .readback_user_clock);
    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One bus access, held until waitrequest is sampled low
    task av(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        avs_read <= ~w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    // Period of the generated clock, one full rising-to-rising span
    task meas(input logic fast);
        int c, ns;
        for (k = 0; k < 1000 && cfg_shift_clock !== 1'b0; k++) @(posedge ref_clk);
        for (k = 0; k < 1000 && cfg_shift_clock !== 1'b1; k++) @(posedge ref_clk);
        for (c = 0; c < 1000 && cfg_shift_clock !== 1'b0; c++) @(posedge ref_clk);
        for (k = c; k < 2000 && cfg_shift_clock !== 1'b1; k++) @(posedge ref_clk);
        ns = k * 4;
        if (fast) chk("fast period ok", 32'h1, 32'(ns >= 100 && ns <= 250));
        else chk("slow period ok", 32'h1, 32'(ns >= 640 && ns <= 2000));
    endtask
    task tally_and_finish;
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog against a hung handshake or wait
    initial begin
        repeat (30000) @(posedge ref_clk);
        miscompares++;
        $display("[FAIL] run time expected finish seen timeout");
        tally_and_finish();
    end
    // Main sequence
    initial begin
        seed = 90346;
        miscompares = 0;
        n_compared = 0;
        exp_stat = 0;
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        av(1'b0, jcrc_pkg::OFF_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        av(1'b1, 4'h2, 32'hffffffff);
        av(1'b0, 4'h2, 32'h0);
        chk("unmapped read", 32'h0, rd);
        av(1'b1, jcrc_pkg::OFF_IRQ_MASK, 32'h9);
        av(1'b0, jcrc_pkg::OFF_IRQ_MASK, 32'h0);
        chk("mask", 32'h9, rd);
        jcrc_scan_model_i.release_clear();
        av(1'b1, jcrc_pkg::OFF_CTRL, 32'h1);
        meas(1'b0);
        av(1'b1, jcrc_pkg::OFF_CTRL, 32'h3);
        meas(1'b1);
        av(1'b1, jcrc_pkg::OFF_CTRL, 32'h0);
        // Length count: one clock short, then the last one
        len = 30 + ($random(seed) & 15);
        jcrc_scan_model_i.shift_bits(len - 1, len[23:0], $random(seed));
        repeat (8) @(posedge ref_clk);
        chk("done early", 32'h0, {31'h0, cfg_done});
        jcrc_scan_model_i.shift_bits(1, len[23:0], $random(seed));
        repeat (8) @(posedge ref_clk);
        chk("done", 32'h1, {31'h0, cfg_done});
        exp_stat = exp_stat | 1;
        av(1'b0, jcrc_pkg::OFF_STATUS, 32'h0);
        chk("tck count", 32'(len), {8'h0, rd[27:4]});
        chk("cfg state", 32'h2, {30'h0, rd[2:1]});
        chk("irq raised", 32'h1, {31'h0, irq});
        av(1'b0, jcrc_pkg::OFF_IRQ_STAT, 32'h0);
        chk("irq stat", 32'(exp_stat), rd);
        exp_stat = 0;
        repeat (2) @(posedge ref_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Readback disabled: trigger must do nothing
        jcrc_scan_model_i.trig(1'b1);
        repeat (20) @(posedge ref_clk);
        chk("rb inhibited", 32'h0, {31'h0, readback_in_progress});
        jcrc_scan_model_i.trig(1'b0);
        av(1'b1, jcrc_pkg::OFF_CTRL, 32'h1c);
        for (int r = 0; r < 2; r++) begin
            jcrc_scan_model_i.trig(1'b1);
            for (k = 0; k < 20 && readback_in_progress !== 1'b1; k++) @(posedge ref_clk);
            chk("rb start", 32'h1, {31'h0, readback_in_progress});
            jcrc_scan_model_i.rb_clocks(20);
            repeat (50) @(posedge ref_clk);
            chk("rb paused", 32'h1, {31'h0, readback_in_progress});
            jcrc_scan_model_i.trig(1'b0);
            for (k = 0; k < 20 && readback_in_progress !== 1'b0; k++) @(posedge ref_clk);
            chk("rb abort", 32'h0, {31'h0, readback_in_progress});
            jcrc_scan_model_i.rb_clocks(4);
        end
        // An abort also ends the readback, so both end and abort are set
        exp_stat = exp_stat | 8 | 4;
        chk("abort irq", 32'h1, {31'h0, irq});
        av(1'b0, jcrc_pkg::OFF_IRQ_STAT, 32'h0);
        chk("abort stat", 32'(exp_stat), rd);
        // Mid-run reset: loader is terminal once done, so restart it
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("done after reset", 32'h0, {31'h0, cfg_done});
        jcrc_scan_model_i.release_clear();
        repeat (8) @(posedge ref_clk);
        // Frame error: device pulls the clear pin low and waits
        av(1'b1, jcrc_pkg::OFF_CTRL, 32'h20);
        for (k = 0; k < 20 && init_n_oe !== 1'b1; k++) @(posedge ref_clk);
        chk("clear pulled", 32'h0, {31'h0, init_n_in});
        av(1'b0, jcrc_pkg::OFF_STATUS, 32'h0);
        chk("wait state", 32'h3, {30'h0, rd[2:1]});
        tally_and_finish();
    end
endmodule // jcrc_ctrl_tb
`default_nettype wire
